// [core/hsp_pkg.sv]
/*
  hsp_pkg: register map, field positions, reset values and shared types
  for the haptic system status and playback control register bank.
  Assumes one 8-bit register space reached through byte-wide
  read and write strobes from the serial host interface front end.
*/
package hsp_pkg;

  // register offsets
  localparam logic [7:0] ADDR_SOFT_RESET   = 8'h00;
  localparam logic [7:0] ADDR_LIVE_STATUS  = 8'h01;
  localparam logic [7:0] ADDR_STICKY_FLAGS = 8'h02;
  localparam logic [7:0] ADDR_IRQ_MASK     = 8'h03;
  localparam logic [7:0] ADDR_REG_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_OUTPUT_GAIN  = 8'h07;
  localparam logic [7:0] ADDR_PLAY_CONFIG  = 8'h08;
  localparam logic [7:0] ADDR_PLAY_COMMAND = 8'h09;
  localparam logic [7:0] ADDR_SLOT_ONE     = 8'h0a;
  localparam logic [7:0] ADDR_SLOT_TWO     = 8'h0b;

  localparam logic [7:0] SOFT_RESET_CODE   = 8'haa;

  // status / flag / mask bit positions
  localparam int BIT_UNDERVOLTAGE = 5;
  localparam int BIT_NEAR_EMPTY   = 4;
  localparam int BIT_NEAR_FULL    = 3;
  localparam int BIT_OVERCURRENT  = 2;
  localparam int BIT_OVERTEMP     = 1;
  localparam int BIT_PLAY_DONE    = 0;
  localparam int NUM_EVENTS       = 6;

  // play config / command / slot fields
  localparam int BIT_STOP_MODE    = 5;
  localparam int BIT_BRAKE_EN     = 2;
  localparam int BIT_STOP         = 1;
  localparam int BIT_START        = 0;
  localparam int BIT_SLOT_DELAY   = 7;

  // regulator status: reserved fields read fixed values
  localparam logic [3:0] REG_STATUS_HI    = 4'h2;
  localparam logic [2:0] REG_STATUS_LO    = 3'h5;
  localparam int         BIT_REG_GOOD     = 3;

  // reset values
  localparam logic [5:0] RST_FLAGS        = 6'h10;
  localparam logic [5:0] RST_MASK         = 6'h3f;
  localparam logic [7:0] RST_GAIN         = 8'h80;
  localparam logic       RST_STOP_MODE    = 1'b0;
  localparam logic       RST_BRAKE_EN     = 1'b1;
  localparam logic [1:0] RST_PLAY_MODE    = 2'h0;
  localparam logic [7:0] RST_SLOT_ONE     = 8'h01;
  localparam logic [7:0] RST_SLOT_TWO     = 8'h00;

  // gain is code / 2**GAIN_SHIFT
  localparam int GAIN_SHIFT = 7;

  typedef enum logic [1:0] {
    MODE_RAM      = 2'b00,
    MODE_REALTIME = 2'b01,
    MODE_CONT     = 2'b10,
    MODE_NONE     = 2'b11
  } hsp_mode_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_PLAY  = 2'b01,
    ST_BRAKE = 2'b10
  } hsp_fsm_t;

  typedef struct packed {
    logic       undervoltage_level;
    logic       stream_buf_near_empty_level;
    logic       stream_buf_near_full_level;
    logic       overcurrent_level;
    logic       overtemp_level;
    logic       playback_done_level;
  } hsp_status_t;

  typedef struct packed {
    logic [5:0] irq_mask;
    logic [7:0] gain;
    logic       stop_mode;
    logic       auto_brake_enable;
    hsp_mode_t  play_mode;
    logic       start;
    logic       stop;
    logic [7:0] slot_one;
    logic [7:0] slot_two;
  } hsp_cfg_t;

  typedef struct packed {
    hsp_cfg_t   cfg;
    logic [5:0] flags;
    hsp_fsm_t   fsm;
    hsp_mode_t  run_mode;
    logic       stop_pend;
    logic [7:0] rdata;
    logic [7:0] scaled;
  } hsp_state_t;

endpackage : hsp_pkg

// [core/hsp_regbank.sv]
/*
  hsp_regbank: system status, sticky interrupt flags, interrupt mask,
  output gain, playback control and the first two sequence slots.
  Assumes the serial host front end delivers byte-wide register
  accesses as one-cycle strobes synchronous to i_clock, and that the
  analog monitors deliver synchronous status levels.
*/
// Contract
// - writing 0xaa to soft reset restores every configuration register default
// - status bit 5 follows battery undervoltage below 2.7 V
// - status bits 4/3 show buffer near-empty/near-full; near-empty reads 1 after reset
// - status bits 2,1,0 show overcurrent, overtemperature, playback as live levels
// - flags latch their status bit since last read; reading clears them
// - near-empty flag resets to 1, other flags reset to 0
// - mask bit 0 lets its flag pull interrupt low; masks default 1
// - waveform samples scaled by gain code over 128; default 0x80 unity
// - stop bit 5 clear finishes current wave, set halts immediately
// - brake enable bit 2 runs automatic brake after playback stops
// - play-mode field selects RAM, realtime, continuous or no playback
// - writing 1 to stop bit ends running playback
// - writing 1 to start bit begins playback in selected mode
// - slot bit 7 makes field a delay in units, else waveform number
// - slot one field resets to 1; slot two and delay bits to 0
`timescale 1ns/1ps
`default_nettype none

module hsp_regbank #(
  parameter int SAMPLE_W = 8
) (
  input  wire logic                i_clock,        // 40 MHz core clock
  input  wire logic                i_rst_n,        // async reset, active low
  input  wire logic                i_wr_en,        // register write strobe
  input  wire logic                i_rd_en,        // register read strobe
  input  wire logic [7:0]          i_addr,         // register offset
  input  wire logic [7:0]          i_wdata,        // write data
  output logic      [7:0]          o_rdata,        // read data, held after read
  input  wire hsp_pkg::hsp_status_t i_status,      // live monitor levels
  input  wire logic                i_regulator_good, // regulator ok level
  input  wire logic                i_wave_end,     // current waveform finished
  input  wire logic                i_seq_done,     // whole sequence finished
  input  wire logic                i_brake_done,   // brake engine finished
  input  wire logic [SAMPLE_W-1:0] i_sample,       // signed waveform sample
  output logic [SAMPLE_W-1:0]      o_sample_scaled, // gain-scaled sample
  output logic                     o_irq_out_n,    // interrupt, active low
  output logic                     o_playing,      // playback engine running
  output hsp_pkg::hsp_mode_t       o_run_mode,     // mode being played
  output logic                     o_halt_now,     // abort current wave, pulse
  output logic                     o_brake_run,    // automatic brake active
  output logic                     o_slot_one_is_delay, // slot one is a delay
  output logic [6:0]               o_slot_one_value,    // slot one code
  output logic                     o_slot_two_is_delay, // slot two is a delay
  output logic [6:0]               o_slot_two_value     // slot two code
);

  // the registered scaled sample in the state struct is 8 bits wide
  if (SAMPLE_W < 2 || SAMPLE_W > 8) begin : g_bad_width
    $error("hsp_regbank: SAMPLE_W must lie in 2..8");
  end

  localparam int PROD_W = SAMPLE_W + 9;

  hsp_pkg::hsp_state_t s_q;
  hsp_pkg::hsp_state_t s_d;

  logic [5:0]        live_vec;
  logic              wr_soft_reset;
  logic              rd_flags;
  logic [PROD_W-1:0] product;
  logic [PROD_W-1:0] shifted;
  logic [SAMPLE_W-1:0] sat_value;

  function automatic logic [7:0] rd_mux(input hsp_pkg::hsp_state_t st, input logic [5:0] live,
                                        input logic [7:0] addr, input logic reg_good);
    logic [7:0] v;
    v = 8'h00;
    case (addr)
      hsp_pkg::ADDR_LIVE_STATUS:  v = {2'h0, live};
      hsp_pkg::ADDR_STICKY_FLAGS: v = {2'h0, st.flags};
      hsp_pkg::ADDR_IRQ_MASK:     v = {2'h0, st.cfg.irq_mask};
      hsp_pkg::ADDR_REG_STATUS:   v = {hsp_pkg::REG_STATUS_HI, reg_good, hsp_pkg::REG_STATUS_LO};
      hsp_pkg::ADDR_OUTPUT_GAIN:  v = st.cfg.gain;
      hsp_pkg::ADDR_PLAY_CONFIG:  v = {2'h0, st.cfg.stop_mode, 2'h0, st.cfg.auto_brake_enable,
                                       st.cfg.play_mode};
      hsp_pkg::ADDR_PLAY_COMMAND: v = {6'h00, st.cfg.stop, st.cfg.start};
      hsp_pkg::ADDR_SLOT_ONE:     v = st.cfg.slot_one;
      hsp_pkg::ADDR_SLOT_TWO:     v = st.cfg.slot_two;
      default:                    v = 8'h00;  // soft reset is write-only, unmapped read zero
    endcase
    return v;
  endfunction

  // slot decode, used for both slots
  function automatic logic [7:0] slot_decode(input logic [7:0] slot);
    return {slot[hsp_pkg::BIT_SLOT_DELAY], slot[6:0]};
  endfunction

  function automatic hsp_pkg::hsp_cfg_t cfg_defaults();
    hsp_pkg::hsp_cfg_t c;
    c.irq_mask          = hsp_pkg::RST_MASK;
    c.gain              = hsp_pkg::RST_GAIN;
    c.stop_mode         = hsp_pkg::RST_STOP_MODE;
    c.auto_brake_enable = hsp_pkg::RST_BRAKE_EN;
    c.play_mode         = hsp_pkg::MODE_RAM;
    c.start             = 1'b0;
    c.stop              = 1'b0;
    c.slot_one          = hsp_pkg::RST_SLOT_ONE;
    c.slot_two          = hsp_pkg::RST_SLOT_TWO;
    return c;
  endfunction

  assign live_vec      = i_status;
  assign wr_soft_reset = i_wr_en && (i_addr == hsp_pkg::ADDR_SOFT_RESET) &&
                         (i_wdata == hsp_pkg::SOFT_RESET_CODE);
  assign rd_flags      = i_rd_en && (i_addr == hsp_pkg::ADDR_STICKY_FLAGS);

  // gain scaling: signed sample times unsigned code, then divide by 128 and saturate
  assign product = PROD_W'($signed(i_sample) * $signed({1'b0, s_q.cfg.gain}));
  assign shifted = PROD_W'($signed(product) >>> hsp_pkg::GAIN_SHIFT);

  always_comb begin
    logic [PROD_W-1:0] max_v;
    logic [PROD_W-1:0] min_v;
    max_v = PROD_W'({1'b0, {(SAMPLE_W-1){1'b1}}});
    min_v = PROD_W'($signed({1'b1, {(SAMPLE_W-1){1'b0}}}));
    if ($signed(shifted) > $signed(max_v)) begin
      sat_value = max_v[SAMPLE_W-1:0];
    end else if ($signed(shifted) < $signed(min_v)) begin
      sat_value = min_v[SAMPLE_W-1:0];
    end else begin
      sat_value = shifted[SAMPLE_W-1:0];
    end
  end

  always_comb begin
    s_d        = s_q;
    s_d.scaled = 8'(sat_value);

    // read data holds until the next read
    if (i_rd_en) begin
      s_d.rdata = rd_mux(s_q, live_vec, i_addr, i_regulator_good);
    end

    // sticky flags: a level present in the clearing read's cycle still sets
    s_d.flags = (rd_flags ? 6'h00 : s_q.flags) | live_vec;

    // register writes; reserved fields are not stored
    if (i_wr_en) begin
      case (i_addr)
        hsp_pkg::ADDR_IRQ_MASK:    s_d.cfg.irq_mask = i_wdata[5:0];
        hsp_pkg::ADDR_OUTPUT_GAIN: s_d.cfg.gain = i_wdata;
        hsp_pkg::ADDR_PLAY_CONFIG: begin
          s_d.cfg.stop_mode         = i_wdata[hsp_pkg::BIT_STOP_MODE];
          s_d.cfg.auto_brake_enable = i_wdata[hsp_pkg::BIT_BRAKE_EN];
          s_d.cfg.play_mode         = hsp_pkg::hsp_mode_t'(i_wdata[1:0]);
        end
        hsp_pkg::ADDR_PLAY_COMMAND: begin
          s_d.cfg.stop  = i_wdata[hsp_pkg::BIT_STOP];
          s_d.cfg.start = i_wdata[hsp_pkg::BIT_START];
        end
        hsp_pkg::ADDR_SLOT_ONE:    s_d.cfg.slot_one = i_wdata;
        hsp_pkg::ADDR_SLOT_TWO:    s_d.cfg.slot_two = i_wdata;
        default: ;
      endcase
    end

    // playback engine; stop is consumed one cycle after it lands, start only once the engine is idle
    case (s_q.fsm)
      hsp_pkg::ST_IDLE: begin
        s_d.stop_pend = 1'b0;
        if (s_q.cfg.start) begin
          s_d.cfg.start = 1'b0;
          if (s_q.cfg.play_mode != hsp_pkg::MODE_NONE) begin
            s_d.fsm      = hsp_pkg::ST_PLAY;
            s_d.run_mode = s_q.cfg.play_mode;
          end
        end
        if (s_q.cfg.stop) begin
          s_d.cfg.stop = 1'b0;
        end
      end
      hsp_pkg::ST_PLAY: begin
        if (s_q.cfg.stop) begin
          s_d.cfg.stop  = 1'b0;
          s_d.stop_pend = 1'b1;
        end
        // immediate stop ends at once, graceful stop waits for the wave end
        if ((s_q.cfg.stop && s_q.cfg.stop_mode) || i_seq_done ||
            ((s_q.cfg.stop || s_q.stop_pend) && i_wave_end)) begin
          s_d.stop_pend = 1'b0;
          s_d.fsm = s_q.cfg.auto_brake_enable ? hsp_pkg::ST_BRAKE : hsp_pkg::ST_IDLE;
        end
      end
      hsp_pkg::ST_BRAKE: begin
        if (s_q.cfg.stop) begin
          s_d.cfg.stop = 1'b0;
        end
        if (i_brake_done) begin
          s_d.fsm = hsp_pkg::ST_IDLE;
        end
      end
      default: s_d.fsm = hsp_pkg::ST_IDLE;
    endcase

    // soft reset returns configuration only; flags and engine state stay
    if (wr_soft_reset) begin
      s_d.cfg = cfg_defaults();
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q.cfg.irq_mask          <= hsp_pkg::RST_MASK;
      s_q.cfg.gain              <= hsp_pkg::RST_GAIN;
      s_q.cfg.stop_mode         <= hsp_pkg::RST_STOP_MODE;
      s_q.cfg.auto_brake_enable <= hsp_pkg::RST_BRAKE_EN;
      s_q.cfg.play_mode         <= hsp_pkg::MODE_RAM;
      s_q.cfg.start             <= 1'b0;
      s_q.cfg.stop              <= 1'b0;
      s_q.cfg.slot_one          <= hsp_pkg::RST_SLOT_ONE;
      s_q.cfg.slot_two          <= hsp_pkg::RST_SLOT_TWO;
      s_q.flags                 <= hsp_pkg::RST_FLAGS;
      s_q.fsm                   <= hsp_pkg::ST_IDLE;
      s_q.run_mode              <= hsp_pkg::MODE_RAM;
      s_q.stop_pend             <= 1'b0;
      s_q.rdata                 <= 8'h00;
      s_q.scaled                <= 8'h00;
    end else begin
      s_q <= s_d;
    end
  end

  // masked flags drive the pin; a mask bit of 1 keeps its flag off it
  assign o_irq_out_n         = ~|(s_q.flags & ~s_q.cfg.irq_mask);
  assign o_rdata             = s_q.rdata;
  assign o_sample_scaled     = s_q.scaled[SAMPLE_W-1:0];
  assign o_playing           = (s_q.fsm == hsp_pkg::ST_PLAY);
  assign o_run_mode          = s_q.run_mode;
  assign o_halt_now          = o_playing && s_q.cfg.stop && s_q.cfg.stop_mode;
  assign o_brake_run         = (s_q.fsm == hsp_pkg::ST_BRAKE);
  assign {o_slot_one_is_delay, o_slot_one_value} = slot_decode(s_q.cfg.slot_one);
  assign {o_slot_two_is_delay, o_slot_two_value} = slot_decode(s_q.cfg.slot_two);

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  a_soft_reset_cfg: assert property (wr_soft_reset |=> s_q.cfg.gain == hsp_pkg::RST_GAIN &&
      s_q.cfg.irq_mask == hsp_pkg::RST_MASK && s_q.cfg.slot_one == hsp_pkg::RST_SLOT_ONE)
    else $error("soft reset code did not restore defaults");
  a_bad_code_keep: assert property (i_wr_en && i_addr == hsp_pkg::ADDR_SOFT_RESET &&
      i_wdata != hsp_pkg::SOFT_RESET_CODE |=> $stable(s_q.cfg.gain))
    else $error("soft reset register changed gain without the code");
  a_flag_latch_event: assert property (|live_vec |=> (s_q.flags & $past(live_vec)) == $past(live_vec))
    else $error("status level was not latched into its flag");
  a_flag_read_clear: assert property (rd_flags && live_vec == 6'h00 ##1 live_vec == 6'h00
      |=> s_q.flags == 6'h00)
    else $error("flag read did not clear the flags");
  a_irq_pin_level: assert property (o_irq_out_n == ((s_q.flags & ~s_q.cfg.irq_mask) == 6'h00))
    else $error("interrupt pin disagrees with masked flags");
  a_start_enters: assert property (s_q.fsm == hsp_pkg::ST_IDLE && s_q.cfg.start &&
      s_q.cfg.play_mode != hsp_pkg::MODE_NONE |=> o_playing && o_run_mode == $past(s_q.cfg.play_mode))
    else $error("start did not begin playback in selected mode");
  a_no_play_mode: assert property (s_q.fsm == hsp_pkg::ST_IDLE && s_q.cfg.play_mode == hsp_pkg::MODE_NONE
      |=> !o_playing)
    else $error("playback started in no-play mode");
  a_halt_at_once: assert property (o_halt_now |=> !o_playing ##0
      (o_brake_run == $past(s_q.cfg.auto_brake_enable)))
    else $error("immediate stop did not end playback with proper brake");
  a_graceful_wait: assert property (o_playing && s_q.cfg.stop && !s_q.cfg.stop_mode && !i_wave_end &&
      !i_seq_done |=> o_playing && s_q.stop_pend)
    else $error("graceful stop ended before the wave finished");
  a_slot_decode: assert property (o_slot_one_is_delay == s_q.cfg.slot_one[7] &&
      o_slot_two_value == s_q.cfg.slot_two[6:0])
    else $error("slot fields decoded wrongly");
  a_unity_gain: assert property (s_q.cfg.gain == hsp_pkg::RST_GAIN |=> o_sample_scaled == $past(i_sample))
    else $error("unity gain did not pass the sample through");
  a_status_live: assert property (i_rd_en && i_addr == hsp_pkg::ADDR_LIVE_STATUS
      |=> o_rdata == {2'h0, $past(live_vec)})
    else $error("status read did not show live levels");

endmodule : hsp_regbank

`default_nettype wire

// [tb/hsp_host_model.sv]
/*
  hsp_host_model: host side of the byte strobe register port,
  standing in for the serial front end's master.
  Assumes one core clock; requests change only at falling edges.
*/
`timescale 1ns/1ps
`default_nettype none

module hsp_host_model (
  input  wire logic       i_clock, // core clock
  input  wire logic [7:0] i_rdata, // read data from the bank
  output logic            o_wr_en, // write strobe
  output logic            o_rd_en, // read strobe
  output logic      [7:0] o_addr,  // register offset
  output logic      [7:0] o_wdata  // write data
);
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr  = 8'h00;
    o_wdata = 8'h00;
  end

  // callers keep reserved fields at 0; the reset check also reads unmapped offset 0x05
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clock);
    o_wr_en = 1'b1;
    o_addr  = a;
    o_wdata = d;
    @(negedge i_clock);
    o_wr_en = 1'b0;
    // released bus never shows the old value
    o_addr  = ~a;
    o_wdata = ~d;
  endtask

  // data is sampled one full cycle late; it stands until the next read
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clock);
    o_rd_en = 1'b1;
    o_addr  = a;
    @(negedge i_clock);
    o_rd_en = 1'b0;
    o_addr  = ~a;
    @(negedge i_clock);
    d = i_rdata;
  endtask
endmodule // hsp_host_model

`default_nettype wire

// [tb/hsp_regbank_test.sv]
/*
  hsp_regbank_test: self-checking bench for the status, flag, mask,
  gain and playback control register bank.
  Assumes the bank with SAMPLE_W 8 and the host model beside it.
*/
`timescale 1ns/1ps
`default_nettype none

module hsp_regbank_test;
  logic                i_clock;
  logic                i_rst_n;
  logic                wr_en;
  logic                rd_en;
  logic [7:0]          addr;
  logic [7:0]          wdata;
  logic [7:0]          rdata;
  logic [5:0]          lv;
  logic                reg_good;
  logic [2:0]          ev;
  logic [7:0]          sample;
  logic [7:0]          scaled;
  logic                irq_n;
  logic                playing;
  hsp_pkg::hsp_mode_t  run_mode;
  logic                halt_now;
  logic                brake_run;
  logic                s1d;
  logic [6:0]          s1v;
  logic                s2d;
  logic [6:0]          s2v;
  logic                halt_seen;
  int                  n_mismatch = 0;
  int                  cmp_count = 0;

  localparam logic [7:0] RADR [10] = '{8'h02, 8'h03, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h00, 8'h05, 8'h04};
  localparam logic [7:0] REXP [10] = '{8'h10, 8'h3f, 8'h80, 8'h04, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h2d};
  localparam logic [7:0] GT [6] = '{8'h80, 8'h40, 8'h40, 8'hff, 8'hff, 8'h00};
  localparam logic [7:0] ST [6] = '{8'h40, 8'h40, 8'hc0, 8'h7f, 8'h80, 8'h55};
  localparam logic [7:0] ET [6] = '{8'h40, 8'h20, 8'he0, 8'h7f, 8'h80, 8'h00};
  localparam logic [1:0] PM [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
  localparam logic       SM [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  localparam logic       BK [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
  localparam logic       SQ [4] = '{1'b0, 1'b0, 1'b0, 1'b1};

  hsp_regbank uut (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_wr_en(wr_en), .i_rd_en(rd_en),
    .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata),
    .i_status(hsp_pkg::hsp_status_t'(lv)), .i_regulator_good(reg_good),
    .i_wave_end(ev[0]), .i_seq_done(ev[1]), .i_brake_done(ev[2]),
    .i_sample(sample), .o_sample_scaled(scaled), .o_irq_out_n(irq_n),
    .o_playing(playing), .o_run_mode(run_mode), .o_halt_now(halt_now),
    .o_brake_run(brake_run), .o_slot_one_is_delay(s1d), .o_slot_one_value(s1v),
    .o_slot_two_is_delay(s2d), .o_slot_two_value(s2v)
  );

  hsp_host_model uhost (
    .i_clock(i_clock), .i_rdata(rdata), .o_wr_en(wr_en), .o_rd_en(rd_en),
    .o_addr(addr), .o_wdata(wdata)
  );

  always #12.5 i_clock = ~i_clock;
  // halt lasts one cycle; sampled mid-cycle, where it is settled
  always @(negedge i_clock) begin
    if (halt_now === 1'b1) halt_seen <= 1'b1;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t %s: saw %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e, input string what);
    logic [7:0] d;
    uhost.rd(a, d);
    chk(d, e, what);
  endtask

  task automatic strobe(input logic [2:0] m);
    @(negedge i_clock);
    ev = m;
    @(negedge i_clock);
    ev = 3'h0;
  endtask

  task automatic pulse(input int i);
    @(negedge i_clock);
    lv = 6'(1 << i);
    @(negedge i_clock);
    lv = 6'h00;
    @(negedge i_clock);
  endtask

  task automatic wt(input logic br, input logic v);
    for (int n = 0; n < 10 && (br ? brake_run : playing) !== v; n++) @(negedge i_clock);
  endtask

  task automatic t_reset;
    for (int k = 0; k < 10; k++) rc(RADR[k], REXP[k], "reset value");
    reg_good = 1'b0;
    rc(8'h04, 8'h25, "regulator status");
    chk({s1d, s1v}, 8'h01, "slot one out");
    chk({s2d, s2v}, 8'h00, "slot two out");
    chk(8'(irq_n), 8'h01, "irq after reset");
    lv = 6'h10;
    rc(8'h01, 8'h10, "near empty live");
    lv = 6'h00;
    rc(8'h02, 8'h10, "near empty flag");
    rc(8'h02, 8'h00, "flags cleared");
    $display("test reset done");
  endtask

  task automatic t_flags;
    for (int i = 0; i < 6; i++) begin
      @(negedge i_clock);
      lv = 6'(1 << i);
      rc(8'h01, 8'(1 << i), "live level");
      lv = 6'h00;
      rc(8'h01, 8'h00, "live level gone");
      rc(8'h02, 8'(1 << i), "sticky flag");
      rc(8'h02, 8'h00, "flag after read");
    end
    $display("test flags done");
  endtask

  task automatic t_irq;
    for (int i = 0; i < 6; i++) begin
      uhost.wr(8'h03, 8'h3f ^ 8'(1 << i));
      pulse(i);
      chk(8'(irq_n), 8'h00, "irq unmasked");
      rc(8'h02, 8'(1 << i), "flag read");
      chk(8'(irq_n), 8'h01, "irq released");
      uhost.wr(8'h03, 8'h3f);
      pulse(i);
      chk(8'(irq_n), 8'h01, "irq masked");
      rc(8'h02, 8'(1 << i), "flag read");
    end
    $display("test irq done");
  endtask

  task automatic t_soft;
    uhost.wr(8'h03, 8'h00);
    uhost.wr(8'h07, 8'h40);
    uhost.wr(8'h08, 8'h21);
    uhost.wr(8'h0a, 8'h85);
    uhost.wr(8'h0b, 8'h83);
    rc(8'h08, 8'h21, "config");
    chk({s1d, s1v}, 8'h85, "slot one delay");
    chk({s2d, s2v}, 8'h83, "slot two delay");
    uhost.wr(8'h00, 8'h55);
    rc(8'h03, 8'h00, "mask kept");
    rc(8'h07, 8'h40, "gain kept");
    rc(8'h0a, 8'h85, "slot kept");
    uhost.wr(8'h00, 8'haa);
    for (int k = 1; k < 8; k++) rc(RADR[k], REXP[k], "soft reset value");
    $display("test soft reset done");
  endtask

  task automatic t_gain;
    for (int k = 0; k < 6; k++) begin
      uhost.wr(8'h07, GT[k]);
      @(negedge i_clock);
      sample = ST[k];
      @(negedge i_clock);
      chk(scaled, ET[k], "scaled sample");
    end
    $display("test gain done");
  endtask

  task automatic t_play;
    for (int k = 0; k < 4; k++) begin
      uhost.wr(8'h08, {2'b00, SM[k], 2'b00, BK[k], PM[k]});
      uhost.wr(8'h09, 8'h01);
      wt(1'b0, 1'b1);
      chk(8'(playing), 8'h01, "playing");
      chk(8'(run_mode), 8'(PM[k]), "run mode");
      halt_seen = 1'b0;
      if (SQ[k]) begin
        strobe(3'b010);
      end else begin
        uhost.wr(8'h09, 8'h02);
        if (!SM[k]) begin
          repeat (4) @(negedge i_clock);
          chk(8'(playing), 8'h01, "finishing wave");
          strobe(3'b001);
        end
      end
      wt(1'b0, 1'b0);
      chk(8'(playing), 8'h00, "stopped");
      chk(8'(halt_seen), 8'(SM[k] & ~SQ[k]), "halt");
      chk(8'(brake_run), 8'(BK[k]), "brake");
      if (BK[k]) begin
        strobe(3'b100);
        wt(1'b1, 1'b0);
        chk(8'(brake_run), 8'h00, "brake over");
      end
    end
    uhost.wr(8'h08, 8'h07);
    uhost.wr(8'h09, 8'h01);
    repeat (6) @(negedge i_clock);
    chk(8'(playing), 8'h00, "no play mode");
    rc(8'h09, 8'h00, "start consumed");
    $display("test play done");
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    i_clock = 1'b0;
    i_rst_n = 1'b0;
    lv = 6'h00;
    reg_good = 1'b1;
    ev = 3'h0;
    sample = 8'h00;
    halt_seen = 1'b0;
    repeat (2) @(negedge i_clock);
    i_rst_n = 1'b1;
    t_reset();
    t_flags();
    t_irq();
    t_soft();
    t_gain();
    t_play();
    stop_test();
  end

  // whole run is near 350 cycles; allow about twenty times that
  initial begin
    #200000;
    n_mismatch++;
    stop_test();
  end
endmodule // hsp_regbank_test

`default_nettype wire
